// >>> pkg/srmb_pkg.sv
package srmb_pkg;
    // array and port geometry
    localparam int          CAP_BITS = 576;
    localparam int          DATA_W   = 18;
    localparam int          ADDR_W   = 9;
    localparam int          TCNT_W   = 5;
    // operating modes, no true dual-port
    typedef enum logic [2:0] {
        MODE_SDP   = 3'h0,
        MODE_SP    = 3'h1,
        MODE_FIFO  = 3'h2,
        MODE_ROM   = 3'h3,
        MODE_SHIFT = 3'h4
    } srmb_mode_e;
    // port shape codes, depth x width
    localparam logic [2:0]  W_X1  = 3'h0;
    localparam logic [2:0]  W_X2  = 3'h1;
    localparam logic [2:0]  W_X4  = 3'h2;
    localparam logic [2:0]  W_X8  = 3'h3;
    localparam logic [2:0]  W_X16 = 3'h4;
    localparam logic [2:0]  W_X9  = 3'h5;
    localparam logic [2:0]  W_X18 = 3'h6;
    // read value when a read collides with a write in dont-care mode
    localparam logic [17:0] DONT_CARE = 18'h3FFFF;
    // controller register offsets
    localparam logic [7:0]  REG_CFG  = 8'h00;
    localparam logic [7:0]  REG_WCMD = 8'h04;
    localparam logic [7:0]  REG_RCMD = 8'h08;
    localparam logic [7:0]  REG_STAT = 8'h0C;
    localparam logic [7:0]  REG_CTRL = 8'h10;
    // field positions
    localparam int          CFG_MODE = 0;
    localparam int          CFG_WW   = 3;
    localparam int          CFG_RW   = 6;
    localparam int          CFG_RSEL = 9;
    localparam int          CFG_QSEL = 10;
    localparam int          CFG_BYP  = 11;
    localparam int          CFG_DC   = 12;
    localparam int          CFG_TLEN = 13;
    localparam int          CFG_TCNT = 22;
    localparam int          WCMD_DAT = 9;
    localparam int          STAT_FUL = 18;
    localparam int          STAT_EMP = 19;
    localparam int          STAT_WP  = 20;
    localparam int          STAT_RP  = 21;
    localparam int          CTL_WCE  = 0;
    localparam int          CTL_RCE  = 1;
    localparam int          CTL_ICLR = 2;
    localparam int          CTL_OCLR = 3;
    localparam int          CTL_INIT = 4;
    localparam logic [31:0] CFG_RST  = 32'h0040_2000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    // clock divider counts for the two block clocks
    localparam int          CLKA_DIV = 2;
    localparam int          CLKB_DIV = 3;

    // bits per word of a shape
    function automatic int wbits(input logic [2:0] c);
        case (c)
            W_X1:    wbits = 1;
            W_X2:    wbits = 2;
            W_X4:    wbits = 4;
            W_X8:    wbits = 8;
            W_X16:   wbits = 16;
            W_X9:    wbits = 9;
            default: wbits = 18;
        endcase
    endfunction

    // address mask of a shape, depth minus one
    function automatic logic [8:0] amask(input logic [2:0] c);
        case (c)
            W_X1:    amask = 9'h1FF;
            W_X2:    amask = 9'h0FF;
            W_X4:    amask = 9'h07F;
            W_X8:    amask = 9'h03F;
            W_X16:   amask = 9'h01F;
            W_X9:    amask = 9'h03F;
            default: amask = 9'h01F;
        endcase
    endfunction
endpackage

// >>> pkg/srmb_if.sv
`timescale 1ns/1ns
interface srmb_if;
    logic              clka_en;
    logic              clkb_en;
    logic              wr_clken;
    logic              rd_clken;
    logic              in_clr;
    logic              out_clr;
    logic              init_load;
    srmb_pkg::srmb_mode_e mode;
    logic [2:0]        wr_shape;
    logic [2:0]        rd_shape;
    logic              rd_sel;
    logic              q_sel;
    logic              q_bypass;
    logic              rdw_dc;
    logic [8:0]        tap_len;
    logic [4:0]        tap_cnt;
    logic              we;
    logic [8:0]        waddr;
    logic [17:0]       wdata;
    logic              re;
    logic [8:0]        raddr;
    logic [17:0]       q;
    logic              full;
    logic              empty;

    modport dev (input clka_en, clkb_en, wr_clken, rd_clken, in_clr, out_clr, init_load, mode,
                 wr_shape, rd_shape, rd_sel, q_sel, q_bypass, rdw_dc, tap_len, tap_cnt,
                 we, waddr, wdata, re, raddr, output q, full, empty);
    modport usr (output clka_en, clkb_en, wr_clken, rd_clken, in_clr, out_clr, init_load, mode,
                 wr_shape, rd_shape, rd_sel, q_sel, q_bypass, rdw_dc, tap_len, tap_cnt,
                 we, waddr, wdata, re, raddr, input q, full, empty);
endinterface

// >>> src/srmb_ram.sv
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module srmb_ram #(
    parameter logic [575:0] INIT_IMAGE = 576'h0
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    srmb_if.dev       bus
);
    // x9 and x18 shapes keep a ninth bit per byte
    logic [575:0] mem_reg;
    logic [575:0] mem_next;
    logic         we_reg,    we_next;
    logic [8:0]   waddr_reg, waddr_next;
    logic [17:0]  wdata_reg, wdata_next;
    logic         re_reg,    re_next;
    logic [8:0]   raddr_reg, raddr_next;
    logic [17:0]  q_reg,     q_next;
    logic [8:0]   wptr_reg,  wptr_next;
    logic [8:0]   rptr_reg,  rptr_next;
    logic [9:0]   cnt_reg,   cnt_next;
    logic [8:0]   sptr_reg,  sptr_next;
    logic [17:0]  q_comb;
    logic         wr_tick, rd_tick, q_tick;
    logic         fifo_full, fifo_empty;

    // write registers tick on clock a only
    // read address and output registers select their clock
    assign wr_tick = bus.clka_en & bus.wr_clken;
    assign rd_tick = (bus.rd_sel ? bus.clkb_en : bus.clka_en) & bus.rd_clken;
    assign q_tick  = (bus.q_sel ? bus.clkb_en : bus.clka_en) & bus.rd_clken;

    // fifo level flags; depth follows the write shape
    assign fifo_full  = (cnt_reg == {1'b0, srmb_pkg::amask(bus.wr_shape)} + 10'h001);
    assign fifo_empty = (cnt_reg == 10'h000);
    assign bus.full   = fifo_full;
    assign bus.empty  = fifo_empty;

    // array next state, read path, fifo and shift pointers
    always_comb begin
        int         wb;
        int         rb;
        int         woff;
        int         roff;
        int         m;
        int         k;
        int         j;
        int         idx;
        logic       wr_do;
        logic       pop;
        logic [8:0] wa;
        wb       = srmb_pkg::wbits(bus.wr_shape);
        rb       = srmb_pkg::wbits(bus.rd_shape);
        m        = (bus.tap_len == 9'h000) ? 1 : int'(bus.tap_len);
        k        = 0;
        j        = 0;
        idx      = 0;
        mem_next = mem_reg;
        q_comb   = 18'h00000;
        wa       = (bus.mode == srmb_pkg::MODE_FIFO) ? wptr_reg : waddr_reg;
        woff     = int'(wa & srmb_pkg::amask(bus.wr_shape)) * wb;
        roff     = int'(raddr_reg & srmb_pkg::amask(bus.rd_shape)) * rb;
        // rom and shift modes refuse plain writes
        // the registered enable is the one-cycle write strobe
        wr_do    = we_reg && bus.mode != srmb_pkg::MODE_ROM && bus.mode != srmb_pkg::MODE_SHIFT
                   && !(bus.mode == srmb_pkg::MODE_FIFO && fifo_full);
        pop      = rd_tick && bus.re && bus.mode == srmb_pkg::MODE_FIFO && !fifo_empty;
        sptr_next = sptr_reg;
        if (bus.mode == srmb_pkg::MODE_SHIFT) begin
            // taps read old words before the new ones land at the edge
            // each strobe moves every line on by one position
            for (int b = 0; b < 18; b++) begin
                k = b / wb;
                j = b % wb;
                idx = (k * m + int'(sptr_reg)) * wb + j;
                if (k < int'(bus.tap_cnt) && idx < srmb_pkg::CAP_BITS) begin
                    q_comb[b] = mem_reg[idx];
                    if (we_reg) begin
                        mem_next[idx] = (k == 0) ? wdata_reg[j] : q_comb[b - wb];
                    end
                end
            end
            if (we_reg) begin
                sptr_next = (int'(sptr_reg) + 1 >= m) ? 9'h000 : sptr_reg + 9'h001;
            end
        end else begin
            // read bit offset scales by the read width
            for (int b = 0; b < 18; b++) begin
                if (b < rb && roff + b < srmb_pkg::CAP_BITS) begin
                    q_comb[b] = mem_reg[roff + b];
                end
            end
            // overlapping write turns the read to dont-care if asked
            if (wr_do && bus.rdw_dc && woff < roff + rb && roff < woff + wb) begin
                q_comb = srmb_pkg::DONT_CARE;
            end
            // write width picks the bit slice
            for (int b = 0; b < 18; b++) begin
                if (wr_do && b < wb && woff + b < srmb_pkg::CAP_BITS) begin
                    mem_next[woff + b] = wdata_reg[b];
                end
            end
        end
        // image load overrides any write in that cycle
        if (bus.init_load) begin
            mem_next = INIT_IMAGE;
        end
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        if (wr_do && bus.mode == srmb_pkg::MODE_FIFO) begin
            wptr_next = (wptr_reg + 9'h001) & srmb_pkg::amask(bus.wr_shape);
        end
        if (pop) begin
            rptr_next = (rptr_reg + 9'h001) & srmb_pkg::amask(bus.wr_shape);
        end
        cnt_next = cnt_reg;
        if ((wr_do && bus.mode == srmb_pkg::MODE_FIFO) && !pop) begin
            cnt_next = cnt_reg + 10'h001;
        end else if (pop && !(wr_do && bus.mode == srmb_pkg::MODE_FIFO)) begin
            cnt_next = cnt_reg - 10'h001;
        end
    end

    // input and output register next values
    always_comb begin
        we_next    = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        re_next    = re_reg;
        raddr_next = raddr_reg;
        q_next     = q_reg;
        // input clear hits only the input registers
        if (bus.in_clr) begin
            waddr_next = 9'h000;
            wdata_next = 18'h00000;
            re_next    = 1'b0;
            raddr_next = 9'h000;
        end else begin
            // every input but re is captured before it acts; re pops the fifo on the tick that captures it
            if (wr_tick) begin
                we_next    = bus.we || bus.mode == srmb_pkg::MODE_SHIFT;
                waddr_next = bus.waddr;
                wdata_next = bus.wdata;
            end
            // single-port reads share the write address; fifo reads use its own pointer
            if (rd_tick) begin
                re_next = bus.re;
                if (bus.mode == srmb_pkg::MODE_SP) begin
                    raddr_next = bus.waddr;
                end else if (bus.mode == srmb_pkg::MODE_FIFO) begin
                    raddr_next = rptr_reg;
                end else begin
                    raddr_next = bus.raddr;
                end
            end
        end
        // output clear hits only the output register
        if (bus.out_clr) begin
            q_next = 18'h00000;
        end else if (q_tick && (re_reg || bus.mode == srmb_pkg::MODE_SHIFT)) begin
            q_next = q_comb;
        end
    end

    // output register is the one stage that may be skipped
    // bypass gives flow-through data from the read address register
    assign bus.q = bus.q_bypass ? q_comb : q_reg;

    // array storage has no reset so clears and reset never disturb contents
    always_ff @(posedge clk_i) begin
        mem_reg <= mem_next;
    end

    // control registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            we_reg    <= 1'b0;
            waddr_reg <= 9'h000;
            wdata_reg <= 18'h00000;
            re_reg    <= 1'b0;
            raddr_reg <= 9'h000;
            q_reg     <= 18'h00000;
            wptr_reg  <= 9'h000;
            rptr_reg  <= 9'h000;
            cnt_reg   <= 10'h000;
            sptr_reg  <= 9'h000;
        end else begin
            we_reg    <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            re_reg    <= re_next;
            raddr_reg <= raddr_next;
            q_reg     <= q_next;
            wptr_reg  <= wptr_next;
            rptr_reg  <= rptr_next;
            cnt_reg   <= cnt_next;
            sptr_reg  <= sptr_next;
        end
    end
endmodule

// >>> src/srmb_ctl.sv
`timescale 1ns/1ns
module srmb_ctl #(
    parameter int CLKA_DIV = srmb_pkg::CLKA_DIV,
    parameter int CLKB_DIV = srmb_pkg::CLKB_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    srmb_if.usr              bus
);
    // the divider counters are eight bits wide
    if (CLKA_DIV < 1 || CLKA_DIV > 256 || CLKB_DIV < 1 || CLKB_DIV > 256) begin : g_div_chk
        $error("clock divider out of range");
    end

    logic [31:0] cfg_reg,   cfg_next;
    logic [31:0] ctrl_reg,  ctrl_next;
    logic [31:0] wcmd_reg,  wcmd_next;
    logic [8:0]  rcmd_reg,  rcmd_next;
    logic        wp_reg,    wp_next;
    logic        rp_reg,    rp_next;
    logic [2:0]  pulse_reg, pulse_next;
    logic [7:0]  cnta_reg,  cnta_next;
    logic [7:0]  cntb_reg,  cntb_next;
    logic [7:0]  aaddr_reg, aaddr_next;
    logic        awr_reg,   awr_next;
    logic [31:0] rdat_reg,  rdat_next;
    logic        wr_tick, rd_tick;
    logic [31:0] stat;

    // the two block clocks become enable pulses from dividers
    assign bus.clka_en   = (cnta_reg == 8'h00);
    assign bus.clkb_en   = (cntb_reg == 8'h00);
    assign bus.wr_clken  = ctrl_reg[srmb_pkg::CTL_WCE];
    assign bus.rd_clken  = ctrl_reg[srmb_pkg::CTL_RCE];
    assign bus.in_clr    = pulse_reg[0];
    assign bus.out_clr   = pulse_reg[1];
    assign bus.init_load = pulse_reg[2];
    assign bus.mode      = srmb_pkg::srmb_mode_e'(cfg_reg[srmb_pkg::CFG_MODE +: 3]);
    assign bus.wr_shape  = cfg_reg[srmb_pkg::CFG_WW +: 3];
    assign bus.rd_shape  = cfg_reg[srmb_pkg::CFG_RW +: 3];
    assign bus.rd_sel    = cfg_reg[srmb_pkg::CFG_RSEL];
    assign bus.q_sel     = cfg_reg[srmb_pkg::CFG_QSEL];
    assign bus.q_bypass  = cfg_reg[srmb_pkg::CFG_BYP];
    assign bus.rdw_dc    = cfg_reg[srmb_pkg::CFG_DC];
    // software keeps tap_len * tap_cnt * width within the array
    // software keeps tap_cnt * width within the data width
    assign bus.tap_len   = cfg_reg[srmb_pkg::CFG_TLEN +: 9];
    assign bus.tap_cnt   = cfg_reg[srmb_pkg::CFG_TCNT +: srmb_pkg::TCNT_W];
    assign bus.we        = wp_reg;
    assign bus.waddr     = wcmd_reg[8:0];
    assign bus.wdata     = wcmd_reg[srmb_pkg::WCMD_DAT +: 18];
    assign bus.re        = rp_reg;
    assign bus.raddr     = rcmd_reg;
    assign wr_tick       = bus.clka_en & bus.wr_clken;
    assign rd_tick       = (bus.rd_sel ? bus.clkb_en : bus.clka_en) & bus.rd_clken;
    assign stat          = {10'h000, rp_reg, wp_reg, bus.empty, bus.full, bus.q};
    // zero wait state slave, always OKAY
    assign hreadyout_o   = 1'b1;
    assign hresp_o       = 1'b0;
    assign hrdata_o      = rdat_reg;

    // bus decode, command registers, divider counters
    always_comb begin
        logic take;
        take       = hsel_i && htrans_i[1] && hready_i;
        aaddr_next = take ? haddr_i[7:0] : aaddr_reg;
        awr_next   = take && hwrite_i;
        rdat_next  = rdat_reg;
        cfg_next   = cfg_reg;
        ctrl_next  = ctrl_reg;
        wcmd_next  = wcmd_reg;
        rcmd_next  = rcmd_reg;
        pulse_next = 3'h0;
        // requests stay up until the block's matching tick takes them
        wp_next    = wp_reg && !wr_tick;
        rp_next    = rp_reg && !rd_tick;
        cnta_next  = (cnta_reg == 8'(CLKA_DIV - 1)) ? 8'h00 : cnta_reg + 8'h01;
        cntb_next  = (cntb_reg == 8'(CLKB_DIV - 1)) ? 8'h00 : cntb_reg + 8'h01;
        if (take && !hwrite_i) begin
            case (haddr_i[7:0])
                srmb_pkg::REG_CFG:  rdat_next = cfg_reg;
                srmb_pkg::REG_WCMD: rdat_next = wcmd_reg;
                srmb_pkg::REG_RCMD: rdat_next = {23'h000000, rcmd_reg};
                srmb_pkg::REG_STAT: rdat_next = stat;
                srmb_pkg::REG_CTRL: rdat_next = {30'h00000000, ctrl_reg[1:0]};
                default:            rdat_next = 32'h00000000;
            endcase
        end
        if (awr_reg) begin
            case (aaddr_reg)
                srmb_pkg::REG_CFG: cfg_next = hwdata_i;
                srmb_pkg::REG_WCMD: begin
                    wcmd_next = hwdata_i;
                    wp_next   = 1'b1;
                end
                srmb_pkg::REG_RCMD: begin
                    rcmd_next = hwdata_i[8:0];
                    rp_next   = 1'b1;
                end
                srmb_pkg::REG_CTRL: begin
                    ctrl_next  = {30'h00000000, hwdata_i[1:0]};
                    pulse_next = hwdata_i[srmb_pkg::CTL_ICLR +: 3];
                end
                default: ;
            endcase
        end
    end

    // controller state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg   <= srmb_pkg::CFG_RST;
            ctrl_reg  <= srmb_pkg::CTRL_RST;
            wcmd_reg  <= 32'h00000000;
            rcmd_reg  <= 9'h000;
            wp_reg    <= 1'b0;
            rp_reg    <= 1'b0;
            pulse_reg <= 3'h0;
            cnta_reg  <= 8'h00;
            cntb_reg  <= 8'h00;
            aaddr_reg <= 8'h00;
            awr_reg   <= 1'b0;
            rdat_reg  <= 32'h00000000;
        end else begin
            cfg_reg   <= cfg_next;
            ctrl_reg  <= ctrl_next;
            wcmd_reg  <= wcmd_next;
            rcmd_reg  <= rcmd_next;
            wp_reg    <= wp_next;
            rp_reg    <= rp_next;
            pulse_reg <= pulse_next;
            cnta_reg  <= cnta_next;
            cntb_reg  <= cntb_next;
            aaddr_reg <= aaddr_next;
            awr_reg   <= awr_next;
            rdat_reg  <= rdat_next;
        end
    end
endmodule

// >>> testbench/srmb_chk.sv
`timescale 1ns/1ns
module srmb_chk #(
    parameter int CLKA_DIV = 2,
    parameter int CLKB_DIV = 3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clka_en,
    input  wire logic        clkb_en,
    input  wire logic        wr_clken,
    input  wire logic        rd_clken,
    input  wire logic        out_clr,
    input  wire logic        init_load,
    input  wire logic        rd_sel,
    input  wire logic        q_bypass,
    input  wire logic        we,
    input  wire logic [8:0]  waddr,
    input  wire logic [17:0] wdata,
    input  wire logic        re,
    input  wire logic [8:0]  raddr,
    input  wire logic [17:0] q,
    input  wire logic        full,
    input  wire logic        empty
);
    logic [8:0] gapa_reg;
    logic [8:0] gapa_next;
    logic [8:0] gapb_reg;
    logic [8:0] gapb_next;
    logic       wtick;
    logic       rtick;

    // capture ticks of each side, read side follows its clock select
    assign wtick = clka_en && wr_clken;
    assign rtick = (rd_sel ? clkb_en : clka_en) && rd_clken;

    // cycles since the last pulse, preset so the first pulse after reset lines up
    always_comb begin
        gapa_next = clka_en ? 9'h0 : gapa_reg + 9'h1;
        gapb_next = clkb_en ? 9'h0 : gapb_reg + 9'h1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gapa_reg <= 9'(CLKA_DIV - 1);
            gapb_reg <= 9'(CLKB_DIV - 1);
        end else begin
            gapa_reg <= gapa_next;
            gapb_reg <= gapb_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_clka_rate: assert property (clka_en == (gapa_reg == 9'(CLKA_DIV - 1)))
        else $error("clock A pulse off its period");
    a_clkb_rate: assert property (clkb_en == (gapb_reg == 9'(CLKB_DIV - 1)))
        else $error("clock B pulse off its period");
    a_we_hold: assert property (we && !wtick |=> we && $stable(waddr) && $stable(wdata))
        else $error("write request moved before its tick");
    a_we_once: assert property (we && wtick |=> !we)
        else $error("write request outlived its tick");
    a_re_hold: assert property (re && !rtick |=> re && $stable(raddr))
        else $error("read request moved before its tick");
    a_re_once: assert property (re && rtick |=> !re)
        else $error("read request outlived its tick");
    a_fifo_flags: assert property (!(full && empty))
        else $error("fifo full and empty together");
    a_out_clear: assert property (out_clr && !q_bypass && !re |=> q == 18'h0)
        else $error("output clear left data on q");
    a_pulse_width: assert property (out_clr || init_load |=> !out_clr && !init_load)
        else $error("clear or load pulse too long");

    c_write: cover property (we && wtick);
    c_read: cover property (re && rtick);
    c_clear: cover property (out_clr);
endmodule

// >>> testbench/test_small_dual_clock_ram_block.sv
`timescale 1ns/1ns
module test_small_dual_clock_ram_block;
    // repeating image, known at every preloaded word
    localparam logic [575:0] IMG = {36{16'hC35A}};
    logic        clk_i   = 1'h0;
    logic        rst_n_i = 1'h0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'h0;
    logic [31:0] hwdata  = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rv;
    int          error_cnt = 0;
    int          checked   = 0;

    srmb_if bus ();
    srmb_ctl i_srmb_ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'h1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .bus(bus));
    srmb_ram #(.INIT_IMAGE(IMG)) i_srmb_ram (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus));
    srmb_chk i_srmb_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .clka_en(bus.clka_en), .clkb_en(bus.clkb_en),
        .wr_clken(bus.wr_clken), .rd_clken(bus.rd_clken), .out_clr(bus.out_clr), .init_load(bus.init_load),
        .rd_sel(bus.rd_sel), .q_bypass(bus.q_bypass), .we(bus.we), .waddr(bus.waddr), .wdata(bus.wdata),
        .re(bus.re), .raddr(bus.raddr), .q(bus.q), .full(bus.full), .empty(bus.empty));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait for hready at a rising edge, the master never assumes a latency
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready !== 1'h1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                print_verdict();
            end
            @(posedge clk_i);
        end
    endtask

    // one single word transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rv = hrdata;
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] m, input logic [2:0] ws, input logic [2:0] rs,
                                        input logic byp);
        cfg = srmb_pkg::CFG_RST | {29'h0, m} | ({29'h0, ws} << srmb_pkg::CFG_WW) |
              ({29'h0, rs} << srmb_pkg::CFG_RW) | ({31'h0, byp} << srmb_pkg::CFG_BYP);
    endfunction

    // poll status until a pending flag drops; a stuck flag ends the run
    task automatic wait_idle(input int b);
        int n;
        n = 0;
        do begin
            ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
            n++;
        end while (rv[b] !== 1'h0 && n < 20);
        if (rv[b] !== 1'h0) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    task automatic write_word(input logic [8:0] a, input logic [17:0] d);
        ahb(1'h1, srmb_pkg::REG_WCMD, {5'h0, d, a});
        wait_idle(srmb_pkg::STAT_WP);
    endtask

    // two extra status reads give the output tick time to land
    task automatic read_word(input logic [8:0] a, input logic [17:0] exp, input string name);
        ahb(1'h1, srmb_pkg::REG_RCMD, {23'h0, a});
        wait_idle(srmb_pkg::STAT_RP);
        ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        chk(name, {14'h0, exp}, {14'h0, rv[17:0]});
    endtask

    task automatic t_reset();
        ahb(1'h0, srmb_pkg::REG_CFG, 32'h0);
        chk("cfg reset", srmb_pkg::CFG_RST, rv);
        ahb(1'h0, 8'h20, 32'h0);
        chk("unmapped read", 32'h0, rv);
        ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        chk("flags reset", 32'h2, {30'h0, rv[19:18]});
    endtask

    task automatic t_rom();
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_ROM, srmb_pkg::W_X18, srmb_pkg::W_X18, 1'h0));
        ahb(1'h1, srmb_pkg::REG_CTRL, 32'h13);
        read_word(9'h2, IMG[36 +: 18], "rom preload");
        write_word(9'h2, 18'h0);
        read_word(9'h2, IMG[36 +: 18], "rom write refused");
    endtask

    // one byte written, then read back through the x1, x2, x4, x8 and x16 shapes
    task automatic t_mixed();
        logic [2:0]  shp [5] = '{srmb_pkg::W_X1, srmb_pkg::W_X2, srmb_pkg::W_X4, srmb_pkg::W_X8, srmb_pkg::W_X16};
        logic [8:0]  adr [5] = '{9'h1F, 9'h0C, 9'h07, 9'h03, 9'h01};
        logic [17:0] exp [5] = '{18'h1, 18'h1, 18'hA, 18'hA5, 18'hA55A};
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SDP, srmb_pkg::W_X8, srmb_pkg::W_X8, 1'h0));
        write_word(9'h3, 18'hA5);
        for (int i = 0; i < 5; i++) begin
            ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SDP, srmb_pkg::W_X8, shp[i], 1'h0));
            read_word(adr[i], exp[i], "mixed width read");
        end
    endtask

    task automatic t_parity_clear();
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SDP, srmb_pkg::W_X9, srmb_pkg::W_X9, 1'h1));
        write_word(9'h5, 18'h1A5);
        read_word(9'h5, 18'h1A5, "bypassed read");
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SDP, srmb_pkg::W_X9, srmb_pkg::W_X9, 1'h0));
        read_word(9'h5, 18'h1A5, "parity bit kept");
        ahb(1'h1, srmb_pkg::REG_CTRL, 32'h0B);
        ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        chk("q after out clear", 32'h0, {14'h0, rv[17:0]});
        read_word(9'h5, 18'h1A5, "array after clear");
    endtask

    task automatic t_fifo();
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_FIFO, srmb_pkg::W_X8, srmb_pkg::W_X8, 1'h0));
        write_word(9'h0, 18'h11);
        write_word(9'h0, 18'h22);
        chk("fifo not empty", 32'h0, {31'h0, rv[srmb_pkg::STAT_EMP]});
        read_word(9'h0, 18'h11, "fifo first pop");
        read_word(9'h0, 18'h22, "fifo second pop");
        chk("fifo empty again", 32'h1, {31'h0, rv[srmb_pkg::STAT_EMP]});
    endtask

    task automatic t_sp();
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SP, srmb_pkg::W_X18, srmb_pkg::W_X18, 1'h0) | 32'h600);
        write_word(9'h1, 18'h2ABCD);
        read_word(9'h0, 18'h2ABCD, "single port on clock B");
    endtask

    task automatic t_shift();
        ahb(1'h1, srmb_pkg::REG_CTRL, 32'h2);
        ahb(1'h1, srmb_pkg::REG_CFG, cfg(srmb_pkg::MODE_SHIFT, srmb_pkg::W_X4, srmb_pkg::W_X4, 1'h0) | 32'h80_0000);
        for (int i = 1; i < 4; i++) begin
            ahb(1'h1, srmb_pkg::REG_WCMD, 32'(i) << srmb_pkg::WCMD_DAT);
            ahb(1'h1, srmb_pkg::REG_CTRL, 32'h3);
            ahb(1'h1, srmb_pkg::REG_CTRL, 32'h2);
        end
        repeat (2) ahb(1'h0, srmb_pkg::REG_STAT, 32'h0);
        chk("shift taps", 32'h123, {14'h0, rv[17:0]});
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        t_reset();
        t_rom();
        t_mixed();
        t_parity_clear();
        t_fifo();
        t_sp();
        t_shift();
        print_verdict();
    end
endmodule
